/* fdp_defs.svh */
/*
  Register offsets, field positions and reset values for the floppy
  drive and host pin logic. Assumes a 3-bit register address.
*/
`ifndef FDP_DEFS_SVH
`define FDP_DEFS_SVH

// ==========================================================
// register offsets
`define FDP_OFS_DRV_CTL 3'h2
`define FDP_OFS_CONFIG 3'h3
`define FDP_OFS_IRQ_STAT 3'h4
`define FDP_OFS_IRQ_MASK 3'h5
`define FDP_OFS_PIN_STAT 3'h6
`define FDP_OFS_DOOR 3'h7

// ==========================================================
// field positions
`define FDP_DC_SEL_LSB 0
`define FDP_DC_IRQ_EN 3
`define FDP_DC_MTR_LSB 4
`define FDP_CFG_RATE_LSB 0
`define FDP_CFG_FM 2
`define FDP_CFG_RG 3
`define FDP_IRQ_INDEX 0
`define FDP_IRQ_DOOR 1
`define FDP_IRQ_ATTN 2
`define FDP_DOOR_BIT 7

// ==========================================================
// reset values
`define FDP_DRV_CTL_RST 8'h00
`define FDP_CONFIG_RST 8'h02
`define FDP_IRQ_RST 3'h0

`endif

/* fdp_pkg.sv */
/*
  Types shared by the floppy drive and host pin logic.
  Assumes the constants of fdp_defs.svh for field positions.
*/
package fdp_pkg;

  // ==========================================================
  // data rate codes
  typedef enum logic [1:0] {
    FDP_RATE_500K = 2'h0,
    FDP_RATE_300K = 2'h1,
    FDP_RATE_250K = 2'h2,
    FDP_RATE_1M = 2'h3
  } fdp_rate_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fdp_bus_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic oe_lo;
    logic oe_hi;
  } fdp_bus_rsp_s;

  typedef struct packed {
    logic [3:0] sel_oe;
    logic head_oe;
    logic lo_gnd_oe;
    logic mid_gnd_oe;
  } fdp_drv_pins_s;

endpackage : fdp_pkg

/* fdp_pin_logic.sv */
/*
  Drive-side and host-side pin logic of a floppy disk controller: drive
  selects, head select, filter ground switching, door/read-gate pin,
  index input, host data bus answer and interrupt gating.
  Assumes a synchronous register port, inputs synchronous to clk_i and
  open-drain pads outside that turn an enable into a pulled-low pin.
*/
`timescale 1ns/1ps
`include "fdp_defs.svh"

module fdp_pin_logic (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire fdp_pkg::fdp_bus_req_s bus_req_i,
  output fdp_pkg::fdp_bus_rsp_s bus_rsp_o,
  input wire logic door_opened_in_i,
  input wire logic index_n_i,
  input wire logic op_attention_i,
  input wire logic head_one_i,
  input wire logic core_read_gate_i,
  output fdp_pkg::fdp_drv_pins_s drive_pins_o,
  output logic [3:0] drive_select_n_o,
  output logic head_choice_out_n_o,
  output logic low_rate_filter_gnd_n_o,
  output logic mid_rate_filter_gnd_n_o,
  output logic read_gate_mode_o,
  output logic sep_lock_data_o,
  output logic track_start_o,
  output logic irq_o
);
  import fdp_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] drv_ctl;
    logic [7:0] cfg;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic door_latch;
    logic door_prev;
    logic index_prev;
    logic irq;
    logic track_start;
    logic sep_lock_data;
    fdp_drv_pins_s pins;
    fdp_bus_rsp_s rsp;
  } fdp_state_s;

  fdp_state_s state_q;
  fdp_state_s state_d;

  // ==========================================================
  // decode helpers
  function automatic logic [3:0] fdp_sel_decode(input logic [7:0] dc);
    logic [3:0] onehot;
    onehot = 4'h0;
    onehot[dc[`FDP_DC_SEL_LSB +: 2]] = 1'b1;
    return onehot & dc[`FDP_DC_MTR_LSB +: 4];
  endfunction : fdp_sel_decode

  // fm halves each code's rate, so the filter follows the code alone
  function automatic logic fdp_low_rate(input logic [7:0] cfg);
    fdp_rate_e rate;
    rate = fdp_rate_e'(cfg[`FDP_CFG_RATE_LSB +: 2]);
    return (rate == FDP_RATE_250K) || (rate == FDP_RATE_300K);
  endfunction : fdp_low_rate

  function automatic logic fdp_mid_rate(input logic [7:0] cfg);
    fdp_rate_e rate;
    rate = fdp_rate_e'(cfg[`FDP_CFG_RATE_LSB +: 2]);
    return rate == FDP_RATE_500K;
  endfunction : fdp_mid_rate

  // ==========================================================
  // next state
  logic wr_hit;
  logic rd_hit;
  logic rg_mode;
  logic [2:0] irq_event;
  logic [7:0] rdata;

  always_comb begin
    state_d = state_q;
    wr_hit = bus_req_i.wr;
    rd_hit = bus_req_i.rd;
    rg_mode = state_q.cfg[`FDP_CFG_RG];
    irq_event = 3'h0;
    rdata = 8'h00;

    // door pin: latched status source, or read gate in diagnostic mode
    if (!rg_mode) begin
      state_d.door_latch = door_opened_in_i;
      state_d.sep_lock_data = core_read_gate_i;
    end else begin
      state_d.sep_lock_data = door_opened_in_i;
    end
    state_d.door_prev = state_q.door_latch;

    // index low is the track start
    state_d.index_prev = index_n_i;
    state_d.track_start = !index_n_i;

    irq_event[`FDP_IRQ_INDEX] = state_q.index_prev && !index_n_i;
    irq_event[`FDP_IRQ_DOOR] = state_q.door_prev != state_q.door_latch;
    irq_event[`FDP_IRQ_ATTN] = op_attention_i;

    // register writes
    if (wr_hit) begin
      unique case (bus_req_i.addr)
        `FDP_OFS_DRV_CTL: begin
          state_d.drv_ctl = bus_req_i.wdata;
        end
        `FDP_OFS_CONFIG: begin
          state_d.cfg = {4'h0, bus_req_i.wdata[3:0]};
        end
        `FDP_OFS_IRQ_STAT: begin
          state_d.irq_stat = state_q.irq_stat & ~bus_req_i.wdata[2:0];
        end
        `FDP_OFS_IRQ_MASK: begin
          state_d.irq_mask = bus_req_i.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // an event in the clearing cycle survives the clear
    state_d.irq_stat = state_d.irq_stat | irq_event;
    state_d.irq = (|(state_d.irq_stat & state_d.irq_mask))
                  && state_d.drv_ctl[`FDP_DC_IRQ_EN];

    // pin enables follow the registered controls, except head_oe, which follows head_one_i
    state_d.pins.sel_oe = fdp_sel_decode(state_q.drv_ctl);
    state_d.pins.head_oe = head_one_i;
    state_d.pins.lo_gnd_oe = fdp_low_rate(state_q.cfg);
    state_d.pins.mid_gnd_oe = fdp_mid_rate(state_q.cfg);

    // register reads; unmapped offsets answer zero
    unique case (bus_req_i.addr)
      `FDP_OFS_DRV_CTL: rdata = state_q.drv_ctl;
      `FDP_OFS_CONFIG: rdata = state_q.cfg;
      `FDP_OFS_IRQ_STAT: rdata = {5'h00, state_q.irq_stat};
      `FDP_OFS_IRQ_MASK: rdata = {5'h00, state_q.irq_mask};
      `FDP_OFS_PIN_STAT: rdata = {3'h0, state_q.sep_lock_data, head_one_i, rg_mode,
                                  state_q.track_start, state_q.door_latch};
      `FDP_OFS_DOOR: rdata[`FDP_DOOR_BIT] = !state_q.door_latch;
      default: rdata = 8'h00;
    endcase

    // bus driven only in the cycle after a read strobe
    state_d.rsp.data = rd_hit ? rdata : 8'h00;
    state_d.rsp.oe_lo = rd_hit;
    state_d.rsp.oe_hi = rd_hit;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q.drv_ctl <= `FDP_DRV_CTL_RST;
      state_q.cfg <= `FDP_CONFIG_RST;
      state_q.irq_stat <= `FDP_IRQ_RST;
      state_q.irq_mask <= `FDP_IRQ_RST;
      state_q.door_latch <= 1'b1;
      state_q.door_prev <= 1'b1;
      state_q.index_prev <= 1'b1;
      state_q.irq <= 1'b0;
      state_q.track_start <= 1'b0;
      state_q.sep_lock_data <= 1'b0;
      state_q.pins <= '0;
      state_q.rsp <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // outputs
  // pads only sink current; a released pin reads high through the pull-up
  assign drive_pins_o = state_q.pins;
  assign drive_select_n_o = ~state_q.pins.sel_oe;
  assign head_choice_out_n_o = !state_q.pins.head_oe;
  assign low_rate_filter_gnd_n_o = !state_q.pins.lo_gnd_oe;
  assign mid_rate_filter_gnd_n_o = !state_q.pins.mid_gnd_oe;
  assign read_gate_mode_o = state_q.cfg[`FDP_CFG_RG];
  assign sep_lock_data_o = state_q.sep_lock_data;
  assign track_start_o = state_q.track_start;
  assign irq_o = state_q.irq;
  assign bus_rsp_o = state_q.rsp;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic wr_drv;
  logic wr_cfg;
  assign wr_drv = bus_req_i.wr && (bus_req_i.addr == `FDP_OFS_DRV_CTL);
  assign wr_cfg = bus_req_i.wr && (bus_req_i.addr == `FDP_OFS_CONFIG);

  chk_drive_select_decode: assert property (
    wr_drv |=> ##1 (drive_pins_o.sel_oe == fdp_sel_decode($past(bus_req_i.wdata, 2)))
  ) else $error("drive select does not follow drive control write");

  chk_select_needs_motor: assert property (
    (wr_drv && bus_req_i.wdata[`FDP_DC_MTR_LSB +: 4] == 4'h0) |=> ##1
      (drive_select_n_o == 4'hf)
  ) else $error("drive selected without its motor enable");

  chk_door_read_bit: assert property (
    (bus_req_i.rd && bus_req_i.addr == `FDP_OFS_DOOR) |=>
      (bus_rsp_o.data[`FDP_DOOR_BIT] == !$past(state_q.door_latch)
       && bus_rsp_o.data[6:0] == 7'h00)
  ) else $error("door status bit wrong on read");

  chk_read_gate_freeze: assert property (
    (state_q.cfg[`FDP_CFG_RG] && !wr_cfg) |=> $stable(state_q.door_latch)
  ) else $error("door latch moved in read-gate mode");

  chk_read_gate_track: assert property (
    (state_q.cfg[`FDP_CFG_RG] && !wr_cfg) |=> (sep_lock_data_o == $past(door_opened_in_i))
  ) else $error("separator does not follow read gate pin");

  chk_low_filter_gnd: assert property (
    (wr_cfg && (bus_req_i.wdata[1:0] == FDP_RATE_250K || bus_req_i.wdata[1:0] == FDP_RATE_300K))
      |=> ##1 (!low_rate_filter_gnd_n_o && mid_rate_filter_gnd_n_o)
  ) else $error("low rate filter ground not switched");

  chk_mid_filter_gnd: assert property (
    (wr_cfg && bus_req_i.wdata[1:0] == FDP_RATE_500K)
      |=> ##1 (!mid_rate_filter_gnd_n_o && low_rate_filter_gnd_n_o)
  ) else $error("mid rate filter ground not switched");

  chk_head_select_pin: assert property (
    head_one_i |=> !head_choice_out_n_o
  ) else $error("head select not pulled low for head 1");

  chk_irq_on_attention: assert property (
    (op_attention_i && state_q.irq_mask[`FDP_IRQ_ATTN]
     && state_q.drv_ctl[`FDP_DC_IRQ_EN] && !bus_req_i.wr) |=> irq_o
  ) else $error("attention did not raise interrupt");

  chk_irq_gated_off: assert property (
    (!state_q.drv_ctl[`FDP_DC_IRQ_EN] && !wr_drv) |=> !irq_o
  ) else $error("interrupt passed while gated off");

  chk_bus_quiet: assert property (
    !$past(bus_req_i.rd) |-> !(bus_rsp_o.oe_lo || bus_rsp_o.oe_hi)
  ) else $error("data bus driven outside a read");

  chk_reset_cleared: assert property (
    $rose(reset_n_i) |-> (state_q.drv_ctl == 8'h00 && !irq_o && drive_select_n_o == 4'hf)
  ) else $error("drive control not cleared by reset");

  chk_open_drain_lvl: assert property (
    wr_drv |=> ##1 (drive_select_n_o == ~fdp_sel_decode($past(bus_req_i.wdata, 2)))
  ) else $error("open-drain select level wrong");

  // ==========================================================
  // event, level and bus-idle assertions
  // checked every edge: a lost set-wins path or a stray bus drive shows up here first
  chk_index_event_set: assert property (
    (state_q.index_prev && !index_n_i) |=> state_q.irq_stat[`FDP_IRQ_INDEX]
  ) else $error("index falling edge did not set its status bit");

  chk_door_event_set: assert property (
    (state_q.door_prev != state_q.door_latch) |=> state_q.irq_stat[`FDP_IRQ_DOOR]
  ) else $error("door change did not set its status bit");

  chk_stat_set_wins: assert property (
    (bus_req_i.wr && bus_req_i.addr == `FDP_OFS_IRQ_STAT && op_attention_i)
      |=> state_q.irq_stat[`FDP_IRQ_ATTN]
  ) else $error("attention lost against a status clear");

  chk_stat_clear: assert property (
    (bus_req_i.wr && bus_req_i.addr == `FDP_OFS_IRQ_STAT && bus_req_i.wdata[`FDP_IRQ_ATTN]
     && !op_attention_i) |=> !state_q.irq_stat[`FDP_IRQ_ATTN]
  ) else $error("attention status not cleared by a one");

  chk_track_start_level: assert property (
    !index_n_i |=> track_start_o
  ) else $error("index low not seen as track start");

  chk_bus_read_drive: assert property (
    bus_req_i.rd |=> (bus_rsp_o.oe_lo && bus_rsp_o.oe_hi)
  ) else $error("data bus not driven after a read");

  chk_bus_idle_zero: assert property (
    !$past(bus_req_i.rd) |-> (bus_rsp_o.data == 8'h00)
  ) else $error("read data not zero outside a read");

  chk_door_latch_follow: assert property (
    !state_q.cfg[`FDP_CFG_RG] |=> (state_q.door_latch == $past(door_opened_in_i))
  ) else $error("door latch does not follow its pin");

  chk_core_gate_source: assert property (
    !state_q.cfg[`FDP_CFG_RG] |=> (sep_lock_data_o == $past(core_read_gate_i))
  ) else $error("separator not on core read gate outside read-gate mode");

  chk_head_zero_pin: assert property (
    !head_one_i |=> head_choice_out_n_o
  ) else $error("head select not released for head 0");

  chk_irq_level_match: assert property (
    irq_o == ((|(state_q.irq_stat & state_q.irq_mask))
              && state_q.drv_ctl[`FDP_DC_IRQ_EN])
  ) else $error("interrupt level disagrees with status, mask and enable");

  chk_select_one_hot: assert property (
    $onehot0(~drive_select_n_o)
  ) else $error("more than one drive selected");

  chk_filter_exclusive: assert property (
    low_rate_filter_gnd_n_o || mid_rate_filter_gnd_n_o
  ) else $error("both filter grounds active");

  chk_fast_rate_filters: assert property (
    (wr_cfg && bus_req_i.wdata[1:0] == FDP_RATE_1M)
      |=> ##1 (low_rate_filter_gnd_n_o && mid_rate_filter_gnd_n_o)
  ) else $error("filter ground active at the fastest rate");

  cov_door_read: cover property (
    bus_req_i.rd && bus_req_i.addr == `FDP_OFS_DOOR ##1 bus_rsp_o.data[`FDP_DOOR_BIT]
  );
  cov_drive3_select: cover property (!drive_select_n_o[3]);
  cov_read_gate_data: cover property (read_gate_mode_o && sep_lock_data_o);
  cov_irq_raised: cover property ($rose(irq_o));
  cov_index_event: cover property ($fell(index_n_i));

endmodule : fdp_pin_logic

/* fdp_drive_model.sv */
/*
  Behavioural floppy drive on the far side of the pin logic.
  Assumes pull-ups on every open-drain line and a bench that drives
  door_open_i and index_go_i on the rising edge.
*/
`timescale 1ns/1ps

module fdp_drive_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic door_open_i,
  input wire logic index_go_i,
  input wire fdp_pkg::fdp_drv_pins_s pins_i,
  output logic door_n_o,
  output logic index_n_o,
  output logic [3:0] sel_level_o
);
  import fdp_pkg::*;
  logic [2:0] idx_q;
  // ==========================================================
  // open-drain lines: pulled low when enabled, else pull-up
  assign sel_level_o = ~pins_i.sel_oe;
  assign index_n_o = (idx_q == 3'h0);
  // ==========================================================
  // door level and index pulse, four cycles low per track
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_q <= 3'h0;
      door_n_o <= 1'b1;
    end else begin
      door_n_o <= ~door_open_i;
      if (index_go_i) begin
        idx_q <= 3'h4;
      end else if (idx_q != 3'h0) begin
        idx_q <= idx_q - 3'h1;
      end
    end
  end
endmodule : fdp_drive_model

/* fdp_pin_logic_tb_top.sv */
/*
  Self-checking bench for the floppy pin logic with a drive model.
  Assumes the register map of fdp_defs.svh and one 200 MHz clock.
*/
`timescale 1ns/1ps
`include "fdp_defs.svh"

module fdp_pin_logic_tb_top;
  import fdp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  fdp_bus_req_s req = '0;
  fdp_bus_rsp_s rsp;
  fdp_drv_pins_s pins;
  logic door_open = 1'b0, index_go = 1'b0, att = 1'b0, head1 = 1'b0, crg = 1'b0;
  logic door_n, index_n, head_n, lo_n, mid_n, rg, lock, tstart, irq;
  logic [3:0] sel_n, sel_lvl;
  logic [7:0] rd_q, d;
  logic [15:0] lf = 16'hf48d;
  int err_count = 0, check_count = 0, drv, sel;

  always #2.5 clk_i = ~clk_i;

  fdp_pin_logic DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_req_i(req),
    .bus_rsp_o(rsp), .door_opened_in_i(door_n), .index_n_i(index_n),
    .op_attention_i(att), .head_one_i(head1), .core_read_gate_i(crg),
    .drive_pins_o(pins), .drive_select_n_o(sel_n), .head_choice_out_n_o(head_n),
    .low_rate_filter_gnd_n_o(lo_n), .mid_rate_filter_gnd_n_o(mid_n),
    .read_gate_mode_o(rg), .sep_lock_data_o(lock), .track_start_o(tstart), .irq_o(irq));

  fdp_drive_model drive (.clk_i(clk_i), .reset_n_i(reset_n_i), .door_open_i(door_open),
    .index_go_i(index_go), .pins_i(pins), .door_n_o(door_n), .index_n_o(index_n),
    .sel_level_o(sel_lvl));

  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1;
    rd_q = rsp.data;
    chk("bus_oe", 8'h03, {6'h0, rsp.oe_hi, rsp.oe_lo});
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    summarize();
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("sel_reset", 8'h0f, {4'h0, sel_n});
    chk("irq_reset", 8'h00, {7'h0, irq});
    for (int i = 0; i < 10; i++) begin
      lf = lfsr(lf);
      d = (i < 4) ? ((8'h10 << i) | i[7:0]) : (lf[7:0] & 8'hf3);
      wr(`FDP_OFS_DRV_CTL, d);
      settle(1);
      drv = d;
      sel = ((1 << (drv & 3)) & (drv >> 4)) & 15;
      chk("drive_sel", 8'h0f & ~sel[7:0], {4'h0, sel_n});
      chk("sel_level", {4'h0, sel_n}, {4'h0, sel_lvl});
    end
    for (int r = 0; r < 8; r++) begin
      wr(`FDP_OFS_CONFIG, r[7:0]);
      settle(1);
      sel = r & 3;
      chk("filters", (sel == 0) ? 8'h2 : (sel == 3) ? 8'h3 : 8'h1, {6'h0, lo_n, mid_n});
    end
    door_open <= 1'b1;
    settle(3);
    rd(`FDP_OFS_DOOR);
    chk("door_open", 8'h80, rd_q);
    @(posedge clk_i);
    door_open <= 1'b0;
    crg <= 1'b1;
    settle(3);
    chk("lock_core", 8'h01, {7'h0, lock});
    rd(`FDP_OFS_DOOR);
    chk("door_shut", 8'h00, rd_q);
    wr(`FDP_OFS_CONFIG, 8'hfa);
    door_open <= 1'b1;
    settle(3);
    chk("rg_mode", 8'h01, {7'h0, rg});
    chk("lock_xtal", 8'h00, {7'h0, lock});
    rd(`FDP_OFS_CONFIG);
    chk("cfg_read", 8'h0a, rd_q);
    rd(`FDP_OFS_DOOR);
    chk("door_frozen", 8'h00, rd_q);
    door_open <= 1'b0;
    settle(3);
    chk("lock_data", 8'h01, {7'h0, lock});
    @(posedge clk_i);
    head1 <= 1'b1;
    settle(3);
    chk("head_one", 8'h02, {6'h0, pins.head_oe, head_n});
    @(posedge clk_i);
    head1 <= 1'b0;
    settle(3);
    chk("head_zero", 8'h01, {7'h0, head_n});
    index_go <= 1'b1;
    @(posedge clk_i);
    index_go <= 1'b0;
    settle(2);
    chk("track_start", 8'h01, {7'h0, tstart});
    settle(6);
    chk("track_idle", 8'h00, {7'h0, tstart});
    wr(`FDP_OFS_IRQ_MASK, 8'h04);
    wr(`FDP_OFS_DRV_CTL, 8'h08);
    att <= 1'b1;
    @(posedge clk_i);
    att <= 1'b0;
    settle(1);
    chk("irq_raised", 8'h01, {7'h0, irq});
    wr(`FDP_OFS_DRV_CTL, 8'h00);
    settle(2);
    chk("irq_gated", 8'h00, {7'h0, irq});
    wr(`FDP_OFS_DRV_CTL, 8'h08);
    settle(2);
    chk("irq_sticky", 8'h01, {7'h0, irq});
    @(posedge clk_i);
    att <= 1'b1;
    wr(`FDP_OFS_IRQ_STAT, 8'h04);
    att <= 1'b0;
    settle(2);
    chk("irq_set_wins", 8'h01, {7'h0, irq});
    wr(`FDP_OFS_IRQ_STAT, 8'h04);
    settle(2);
    chk("irq_cleared", 8'h00, {7'h0, irq});
    wr(`FDP_OFS_DRV_CTL, 8'h18);
    att <= 1'b1;
    @(posedge clk_i);
    att <= 1'b0;
    settle(1);
    chk("sel_before_reset", 8'h0e, {4'h0, sel_n});
    chk("irq_before_reset", 8'h01, {7'h0, irq});
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("sel_mid_reset", 8'h0f, {4'h0, sel_n});
    chk("irq_mid_reset", 8'h00, {7'h0, irq});
    rd(`FDP_OFS_DRV_CTL);
    chk("drv_ctl_reset", 8'h00, rd_q);
    summarize();
  end
endmodule : fdp_pin_logic_tb_top
